// ### logic/trap_ctrl_map.svh
// Register offsets, field positions and reset values of the trap control block.
`ifndef TRAP_CTRL_MAP_SVH
`define TRAP_CTRL_MAP_SVH
`define TRAP_CTRL_OFF 12'h000
`define IRQ_STATUS_OFF 12'h004
`define IRQ_MASK_OFF 12'h008
`define IPL_OFF 12'h00c
`define TRAP_CTRL_RESET 16'h0000
`define BIT_NEST_DIS 15
`define BIT_OVA_FLAG 14
`define BIT_OVB_FLAG 13
`define BIT_COVA_FLAG 12
`define BIT_COVB_FLAG 11
`define BIT_OVA_TE 10
`define BIT_OVB_TE 9
`define BIT_COV_TE 8
`define BIT_SHIFT_ERR 7
`define BIT_DIV0_ERR 6
`define BIT_MATH_ERR 4
`define BIT_ADDR_ERR 3
`define BIT_STACK_ERR 2
`define BIT_OSC_FAIL 1
`define TRAP_CTRL_IMPL 16'hffde
`define TRAP_EVT_W 9
`endif

// ### logic/trap_ctrl_pkg.sv
// Types shared by the trap control block.
package trap_ctrl_pkg;
    typedef struct packed {
        logic ova;
        logic ovb;
        logic cova;
        logic covb;
        logic shift_err;
        logic div0;
        logic addr_err;
        logic stack_err;
        logic osc_fail;
    } trap_evt_t;

    typedef enum logic [1:0] {
        APB_IDLE,
        APB_SETUP,
        APB_ACCESS
    } apb_state_t;
endpackage : trap_ctrl_pkg

// ### logic/sync_flag.sv
// Two-stage synchroniser followed by a rising-edge pulse.
`timescale 1ns/1ps
module sync_flag
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Asynchronous level in, synchronous pulse out
    input wire logic din,
    output logic pulse
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic s1_d;
    logic s2_d;
    logic s3_d;

    always_comb
    begin
        s1_d = din;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s1_q <= 1'h0;
            s2_q <= 1'h0;
            s3_q <= 1'h0;
        end
        else
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    assign pulse = s2_q & ~s3_q;
endmodule : sync_flag

// ### logic/trap_ctrl.sv
// Trap control and status register with APB access and interrupt.
`timescale 1ns/1ps
`include "trap_ctrl_map.svh"
// Notes on behaviour
// - Catastrophic A flag, bit 12, read/write.
// - Catastrophic overflow of A sets flag when bit 8 is set.
// - Catastrophic B flag, bit 11, read/write.
// - Catastrophic overflow of B sets flag when bit 8 is set.
// - Bit 10 enables accumulator A overflow trap.
// - Nesting disable makes priority bits read-only.
// - Stack error trap sets bit 2.
// - Oscillator failure trap sets bit 1.
module trap_ctrl
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Datapath trap events, same clock
    input wire trap_ctrl_pkg::trap_evt_t evt,
    // Oscillator monitor, asynchronous level
    input wire logic osc_fail_in,
    // Trap requests and status
    output logic trap_req,
    output logic [2:0] ipl,
    output logic irq
);
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [15:0] stat_q;
    logic [15:0] stat_d;
    logic [15:0] mask_q;
    logic [15:0] mask_d;
    logic [2:0] ipl_q;
    logic [2:0] ipl_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic trap_q;
    logic trap_d;
    logic irq_q;
    logic irq_d;
    logic osc_pulse;
    logic acc;
    logic wr;
    logic rd;
    logic [15:0] set_v;

    sync_flag osc_sync
    (
        .mclk(mclk),
        .rst(rst),
        .din(osc_fail_in),
        .pulse(osc_pulse)
    );

    // Slave answers in the cycle after penable rises: one wait state.
    assign acc = psel & penable & ~pready_q;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;

    always_comb
    begin
        set_v = 16'h0000;
        set_v[`BIT_OVA_FLAG] = evt.ova & ctrl_q[`BIT_OVA_TE];
        set_v[`BIT_OVB_FLAG] = evt.ovb & ctrl_q[`BIT_OVB_TE];
        set_v[`BIT_COVA_FLAG] = evt.cova & ctrl_q[`BIT_COV_TE];
        set_v[`BIT_COVB_FLAG] = evt.covb & ctrl_q[`BIT_COV_TE];
        set_v[`BIT_SHIFT_ERR] = evt.shift_err;
        set_v[`BIT_DIV0_ERR] = evt.div0;
        set_v[`BIT_MATH_ERR] = evt.div0 | evt.shift_err;
        set_v[`BIT_ADDR_ERR] = evt.addr_err;
        set_v[`BIT_STACK_ERR] = evt.stack_err;
        set_v[`BIT_OSC_FAIL] = osc_pulse;
    end

    always_comb
    begin
        ctrl_d = ctrl_q;
        stat_d = stat_q;
        mask_d = mask_q;
        ipl_d = ipl_q;
        prdata_d = 32'h00000000;
        pready_d = acc;
        pslverr_d = 1'h0;
        if (wr)
        begin
            if (paddr == `TRAP_CTRL_OFF)
                ctrl_d = pwdata[15:0] & `TRAP_CTRL_IMPL;
            else if (paddr == `IRQ_MASK_OFF)
                mask_d = pwdata[15:0] & `TRAP_CTRL_IMPL;
            else if (paddr == `IPL_OFF)
            begin
                if (!ctrl_q[`BIT_NEST_DIS])
                    ipl_d = pwdata[2:0];
            end
            else if (paddr != `IRQ_STATUS_OFF)
                pslverr_d = 1'h1;
        end
        else if (rd)
        begin
            if (paddr == `TRAP_CTRL_OFF)
                prdata_d = {16'h0000, ctrl_q};
            else if (paddr == `IRQ_STATUS_OFF)
            begin
                prdata_d = {16'h0000, stat_q};
                stat_d = 16'h0000;
            end
            else if (paddr == `IRQ_MASK_OFF)
                prdata_d = {16'h0000, mask_q};
            else if (paddr == `IPL_OFF)
                prdata_d = {29'h0, ipl_q};
            else
                pslverr_d = 1'h1;
        end
        // Hardware sets win over a software write or read clear.
        ctrl_d = ctrl_d | set_v;
        stat_d = stat_d | set_v;
        trap_d = |set_v;
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= `TRAP_CTRL_RESET;
            stat_q <= 16'h0000;
            mask_q <= 16'h0000;
            ipl_q <= 3'h0;
            prdata_q <= 32'h00000000;
            pready_q <= 1'h0;
            pslverr_q <= 1'h0;
            trap_q <= 1'h0;
            irq_q <= 1'h0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            ipl_q <= ipl_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            trap_q <= trap_d;
            irq_q <= irq_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign trap_req = trap_q;
    assign ipl = ipl_q;
    assign irq = irq_q;

    property p_flag_set(logic ev, logic en, int b);
        @(posedge mclk) disable iff (rst) (ev && en) |=> ctrl_q[b];
    endproperty

    cova_set_a: assert property (
        p_flag_set(evt.cova, ctrl_q[`BIT_COV_TE], `BIT_COVA_FLAG))
        else $error("cat A flag not set");
    covb_set_a: assert property (
        p_flag_set(evt.covb, ctrl_q[`BIT_COV_TE], `BIT_COVB_FLAG))
        else $error("cat B flag not set");
    ova_trap_a: assert property (
        p_flag_set(evt.ova, ctrl_q[`BIT_OVA_TE], `BIT_OVA_FLAG))
        else $error("A overflow not trapped");
    ovb_trap_a: assert property (
        p_flag_set(evt.ovb, ctrl_q[`BIT_OVB_TE], `BIT_OVB_FLAG))
        else $error("B overflow not trapped");
    ova_mask_a: assert property (
        @(posedge mclk) disable iff (rst)
        (!ctrl_q[`BIT_OVA_TE] && !wr && !$past(ctrl_q[`BIT_OVA_FLAG])
        && !ctrl_q[`BIT_OVA_FLAG] && evt.ova && !evt.ovb && !evt.cova
        && !evt.covb && !evt.div0 && !evt.shift_err && !evt.addr_err
        && !evt.stack_err && !osc_pulse) |=> !trap_req)
        else $error("suppressed A trap fired");
    ipl_lock_a: assert property (
        @(posedge mclk) disable iff (rst)
        ctrl_q[`BIT_NEST_DIS] |=> $stable(ipl_q))
        else $error("priority changed while locked");
    stack_set_a: assert property (
        @(posedge mclk) disable iff (rst)
        evt.stack_err |=> ctrl_q[`BIT_STACK_ERR] ##0 irq_q == |(stat_q
        & mask_q)) else $error("stack flag not set");
    osc_set_a: assert property (
        @(posedge mclk) disable iff (rst)
        $rose(osc_fail_in) |-> ##[3:4] ctrl_q[`BIT_OSC_FAIL])
        else $error("oscillator flag not set");
    wr_cova_a: assert property (
        @(posedge mclk) disable iff (rst)
        (wr && paddr == `TRAP_CTRL_OFF && !evt.cova) |=>
        ctrl_q[`BIT_COVA_FLAG] == $past(pwdata[`BIT_COVA_FLAG]))
        else $error("cat A flag not writable");
    wr_covb_a: assert property (
        @(posedge mclk) disable iff (rst)
        (wr && paddr == `TRAP_CTRL_OFF && !evt.covb) |=>
        ctrl_q[`BIT_COVB_FLAG] == $past(pwdata[`BIT_COVB_FLAG]))
        else $error("cat B flag not writable");

    cov_cova_c: cover property (@(posedge mclk) evt.cova ##1 trap_req);
    cov_irq_c: cover property (@(posedge mclk) $rose(irq));
    cov_lock_c: cover property (@(posedge mclk)
        ctrl_q[`BIT_NEST_DIS] && wr && paddr == `IPL_OFF);
    cov_rdclr_c: cover property (@(posedge mclk)
        rd && paddr == `IRQ_STATUS_OFF && |stat_q);
endmodule : trap_ctrl

// ### verif/tb_top.sv
// Self-checking bench for the trap control register block.
`timescale 1ns/1ps
module tb_top;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr;
    logic osc_fail_in, trap_req, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] ipl;
    trap_ctrl_pkg::trap_evt_t evt;
    int errors = 0;
    int check_count = 0;

    trap_ctrl trap_ctrl_i (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt(evt), .osc_fail_in(osc_fail_in),
        .trap_req(trap_req), .ipl(ipl), .irq(irq));

    initial
    begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    task print_verdict;
        if (errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Signals change by non-blocking assignment on a rising edge; pready
    // is read right after the edge, so it holds the value that edge saw.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        if (n >= 20)
        begin
            errors++;
            $display("unexpected at %0t: no bus answer", $time);
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task pulse(input logic [8:0] v, input logic t);
        @(posedge mclk);
        evt <= trap_ctrl_pkg::trap_evt_t'(v);
        @(posedge mclk);
        evt <= trap_ctrl_pkg::trap_evt_t'(9'h000);
        @(negedge mclk);
        chk({31'h0, trap_req}, {31'h0, t});
    endtask : pulse

    task t_rw;
        apb(1'h1, 12'h000, 32'h1800);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h1800);
        apb(1'h1, 12'h000, 32'h0800);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h0800);
        apb(1'h1, 12'h000, 32'hffff);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'hffde);
    endtask : t_rw

    task t_flags;
        apb(1'h1, 12'h000, 32'h0100);
        pulse(9'h040, 1'h1);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h1100);
        apb(1'h1, 12'h000, 32'h0100);
        pulse(9'h020, 1'h1);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h0900);
        // The A and B overflow traps are each tried both suppressed and enabled.
        for (int i = 0; i < 2; i++)
        begin
            apb(1'h1, 12'h000, 32'h0);
            pulse(9'h100 >> i, 1'h0);
            apb(1'h0, 12'h000, 32'h0);
            chk(rd, 32'h0);
            apb(1'h1, 12'h000, 32'h0400 >> i);
            pulse(9'h100 >> i, 1'h1);
            apb(1'h0, 12'h000, 32'h0);
            chk(rd, 32'h4400 >> i);
        end
        apb(1'h1, 12'h000, 32'h0);
        // Stack, shift, divide and address errors together; the math
        // flag follows the shift and divide errors.
        pulse(9'h01e, 1'h1);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h00dc);
        apb(1'h1, 12'h000, 32'h0);
        @(posedge mclk);
        osc_fail_in <= 1'h1;
        repeat (6) @(posedge mclk);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h0002);
        osc_fail_in <= 1'h0;
    endtask : t_flags

    task t_ipl;
        apb(1'h1, 12'h00c, 32'h5);
        chk({29'h0, ipl}, 32'h5);
        apb(1'h1, 12'h000, 32'h8000);
        apb(1'h1, 12'h00c, 32'h2);
        apb(1'h0, 12'h00c, 32'h0);
        chk(rd, 32'h5);
        apb(1'h1, 12'h000, 32'h0);
        apb(1'h1, 12'h00c, 32'h2);
        chk({29'h0, ipl}, 32'h2);
    endtask : t_ipl

    task t_irq;
        apb(1'h0, 12'h004, 32'h0);
        apb(1'h1, 12'h008, 32'h1000);
        apb(1'h1, 12'h000, 32'h0100);
        pulse(9'h040, 1'h1);
        @(negedge mclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'h0, 12'h004, 32'h0);
        chk(rd, 32'h1000);
        repeat (2) @(negedge mclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'h1, 12'h008, 32'h0);
        pulse(9'h020, 1'h1);
        repeat (2) @(negedge mclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'h0, 12'h004, 32'h0);
        chk(rd, 32'h0800);
        apb(1'h0, 12'h010, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask : t_irq

    // A reset in mid-run must clear every field, the outputs included.
    task t_reset;
        apb(1'h1, 12'h000, 32'hffff);
        apb(1'h1, 12'h008, 32'hffff);
        pulse(9'h002, 1'h1);
        @(posedge mclk);
        rst <= 1'h1;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        chk({27'h0, trap_req, ipl, irq}, 32'h0);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 12'h008, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 12'h004, 32'h0);
        chk(rd, 32'h0);
    endtask : t_reset

    initial
    begin
        rst = 1'h1;
        {psel, penable, pwrite, osc_fail_in} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        evt = trap_ctrl_pkg::trap_evt_t'(9'h000);
        repeat (4) @(posedge mclk);
        rst <= 1'h0;
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        chk({28'h0, ipl, irq}, 32'h0);
        chk({31'h0, err}, 32'h0);
        t_rw();
        t_flags();
        t_ipl();
        t_irq();
        t_reset();
        print_verdict();
    end
endmodule : tb_top
